// ### rtl/rsws_pkg.sv
// package: timing constants, states and carrier types for the sleep/wake sequencer
package rsws_pkg;

  // ----------------------------------------
  // clock
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;

  // ----------------------------------------
  // timing figures as printed, and derived cycle counts
  // ----------------------------------------
  localparam int POWERDOWN_TO_OSC_OUT_DELAY_US = 2000;
  localparam int WAKE_TO_CLOCKS_US             = 2000;
  localparam int WAKE_TO_IRQ_US                = 2000;
  localparam int WAKE_TO_STABLE_US             = 2100;
  localparam int INTERRUPT_TO_CLOCK_STABLE_US  = 2100;
  localparam int SLEEP_ENTRY_NS                = 50;

  // typical delays round down; sleep entry clamped to at least one cycle
  localparam int OSC_OUT_CYCLES   = (POWERDOWN_TO_OSC_OUT_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int CLOCKS_CYCLES    = (WAKE_TO_CLOCKS_US * 1000) / CLK_PERIOD_NS;
  localparam int IRQ_CYCLES       = (WAKE_TO_IRQ_US * 1000) / CLK_PERIOD_NS;
  localparam int STABLE_CYCLES    = (WAKE_TO_STABLE_US * 1000) / CLK_PERIOD_NS;
  localparam int IRQ_STABLE_CYCLES = (INTERRUPT_TO_CLOCK_STABLE_US * 1000) / CLK_PERIOD_NS;
  localparam int SLEEP_CYCLES_RAW = (SLEEP_ENTRY_NS) / CLK_PERIOD_NS;
  localparam int SLEEP_CYCLES     = (SLEEP_CYCLES_RAW < 1) ? 1 : SLEEP_CYCLES_RAW;

  localparam int CNT_W = 17;

  // ----------------------------------------
  // configuration field layout
  // ----------------------------------------
  localparam int CFG_POL_BIT   = 0;
  localparam int CFG_DRIVE_BIT = 1;
  localparam int WAKE_EN_BIT   = 0;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic       WAKE_EN_RESET = 1'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    RSWS_SLEEP,
    RSWS_WAKING,
    RSWS_AWAKE
  } rsws_state_t;

  typedef struct packed {
    logic osc_out_en;
    logic clocks_running;
    logic clock_stable;
    logic low_power;
  } rsws_status_t;

  typedef struct packed {
    logic o;
    logic oe;
  } rsws_pin_t;

endpackage : rsws_pkg

// ### rtl/rsws_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module rsws_sync #(
  parameter logic RESET_VAL = 1'h0
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (ce) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : rsws_sync

// ### rtl/rsws_top.sv
// sleep/wake sequencer: power-down pin to oscillator, clocks and wake interrupt
// Functional notes
// - oscillator output enabled 2000 us after power-down release.
// - internal clocks running 2000 us after power-down release.
// - low power mode entered within 50 ns of power-down assertion; here on the third clock edge after it.
// - release is wake event; with wake enable, interrupt after 2000 us.
// - oscillator stable 2100 us after power-down release.
// - clock stable 2100 us after wake interrupt asserts; here set 2100 us after release, 100 us after the interrupt.
// - interrupt polarity and drive set by configuration bits 1:0.
`timescale 1ns/100ps
module rsws_top
  import rsws_pkg::*;
#(
  parameter int OSC_OUT_CNT    = OSC_OUT_CYCLES,
  parameter int CLOCKS_CNT     = CLOCKS_CYCLES,
  parameter int IRQ_CNT        = IRQ_CYCLES,
  parameter int STABLE_CNT     = STABLE_CYCLES,
  parameter int IRQ_STABLE_CNT = IRQ_STABLE_CYCLES
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         power_down_n,
  input  wire logic [1:0]   irq_config,
  input  wire logic         wake_enable,
  input  wire logic         irq_clear,
  output rsws_status_t      status,
  output rsws_pin_t         irq_pin,
  output logic              buffered_osc_output_en
);

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  logic pd_n_sync;

  rsws_sync #(
    .RESET_VAL (1'h0)
  ) u_pd_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .ce       (ce),
    .async_in (power_down_n),
    .sync_out (pd_n_sync)
  );

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  rsws_state_t       state;
  rsws_state_t       next_state;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  next_count;
  logic              irq_event;
  logic              next_irq_event;
  rsws_status_t      next_status;
  logic [CNT_W-1:0]  irq_count;
  logic [CNT_W-1:0]  next_irq_count;
  logic              irq_timing;
  logic              next_irq_timing;
  logic              irq_set;

  always_comb begin
    next_state      = state;
    next_count      = count;
    next_status     = status;
    next_irq_event  = irq_event;
    next_irq_count  = irq_count;
    next_irq_timing = irq_timing;
    // power-down dominates the wake interrupt as well
    irq_set = pd_n_sync && (state != RSWS_SLEEP) && wake_enable
              && (count + 1'b1 == CNT_W'(IRQ_CNT));
    unique case (state)
      RSWS_SLEEP: begin
        if (pd_n_sync) begin
          next_state = RSWS_WAKING;
          next_count = '0;
          next_status.low_power = 1'b0;
        end
      end
      RSWS_WAKING, RSWS_AWAKE: begin
        next_count = (count == CNT_W'(STABLE_CNT)) ? count : count + 1'b1;
        if (count + 1'b1 == CNT_W'(OSC_OUT_CNT))
          next_status.osc_out_en = 1'b1;
        if (count + 1'b1 == CNT_W'(CLOCKS_CNT))
          next_status.clocks_running = 1'b1;
        if (count + 1'b1 == CNT_W'(STABLE_CNT)) begin
          next_status.clock_stable = 1'b1;
          next_state = RSWS_AWAKE;
        end
        if (irq_set) begin
          next_irq_event  = 1'b1;
          next_irq_timing = 1'b1;
          next_irq_count  = '0;
        end
        if (irq_timing) begin
          next_irq_count = irq_count + 1'b1;
          if (irq_count + 1'b1 == CNT_W'(IRQ_STABLE_CNT))
            next_irq_timing = 1'b0;
        end
      end
    endcase
    // set wins over clear
    if (irq_clear && !irq_set)
      next_irq_event = 1'b0;
    if (!pd_n_sync) begin
      // power-down dominates: sleep on the next edge
      next_state      = RSWS_SLEEP;
      next_count      = '0;
      next_status     = '{osc_out_en: 1'b0, clocks_running: 1'b0,
                          clock_stable: 1'b0, low_power: 1'b1};
      next_irq_timing = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state      <= RSWS_SLEEP;
      count      <= '0;
      status     <= '{osc_out_en: 1'b0, clocks_running: 1'b0,
                      clock_stable: 1'b0, low_power: 1'b1};
      irq_event  <= 1'b0;
      irq_count  <= '0;
      irq_timing <= 1'b0;
    end else if (ce) begin
      state      <= next_state;
      count      <= next_count;
      status     <= next_status;
      irq_event  <= next_irq_event;
      irq_count  <= next_irq_count;
      irq_timing <= next_irq_timing;
    end
  end

  // ----------------------------------------
  // interrupt pin: polarity bit 0, drive bit 1 (1 = open drain)
  // ----------------------------------------
  rsws_pin_t next_irq_pin;
  logic      irq_level;

  always_comb begin
    irq_level = irq_event ^ ~irq_config[CFG_POL_BIT];
    if (irq_config[CFG_DRIVE_BIT]) begin
      next_irq_pin.o  = 1'b0;
      next_irq_pin.oe = ~irq_level;
    end else begin
      next_irq_pin.o  = irq_level;
      next_irq_pin.oe = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_pin                <= '{o: 1'b1, oe: 1'b1};
      buffered_osc_output_en <= 1'b0;
    end else if (ce) begin
      irq_pin                <= next_irq_pin;
      buffered_osc_output_en <= next_status.osc_out_en;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || !ce);

  sequence s_released;
    $rose(pd_n_sync);
  endsequence

  a_sleep_entry: assert property (!pd_n_sync |=> status.low_power && !status.osc_out_en)
    else $error("low power not entered after power-down");

  a_osc_before_time: assert property (status.osc_out_en |-> count >= CNT_W'(OSC_OUT_CNT))
    else $error("oscillator output enabled early");

  a_osc_pin_match: assert property ($rose(buffered_osc_output_en) |-> count == CNT_W'(OSC_OUT_CNT))
    else $error("oscillator pin enabled off time");

  a_clocks_time: assert property (status.clocks_running |-> count >= CNT_W'(CLOCKS_CNT))
    else $error("clocks running early");

  a_stable_time: assert property (status.clock_stable |-> count >= CNT_W'(STABLE_CNT))
    else $error("clock stable early");

  a_wake_start: assert property (s_released |=> state == RSWS_WAKING && count == '0)
    else $error("wake not started on release");

  a_irq_gate: assert property ($rose(irq_event) |-> wake_enable || $past(wake_enable))
    else $error("wake interrupt without enable");

  a_irq_stable: assert property ($fell(irq_timing) && pd_n_sync |-> status.clock_stable)
    else $error("clock not stable after interrupt interval");

  a_irq_drive: assert property (irq_config[CFG_DRIVE_BIT] && $stable(irq_config)
                                |=> !irq_pin.o)
    else $error("open drain pin drives high");

  // ----------------------------------------
  // wake interrupt timing
  // ----------------------------------------
  sequence s_irq_due;
    pd_n_sync && wake_enable && state != RSWS_SLEEP && count == CNT_W'(IRQ_CNT - 1);
  endsequence

  a_irq_set: assert property (s_irq_due |=> irq_event)
    else $error("wake interrupt not raised on time");

  a_irq_time: assert property ($rose(irq_event) |-> count == CNT_W'(IRQ_CNT))
    else $error("wake interrupt raised off time");

  a_irq_clear: assert property (irq_clear && !irq_set |=> !irq_event)
    else $error("wake interrupt not cleared");

  a_irq_pin_level: assert property ($rose(irq_event) && !irq_config[CFG_DRIVE_BIT]
                                    |=> irq_pin.o == $past(irq_config[CFG_POL_BIT]))
    else $error("interrupt pin level wrong for polarity");

endmodule : rsws_top

// ### test/rsws_host_model.sv
// host model: drives the power-down pin with its own timers
`timescale 1ns/100ps
module rsws_host_model #(
  parameter int POWERON_CYC = 32500,
  parameter int PULSE_CYC   = 260
) (
  input  wire logic clk_sys,
  output logic      power_down_n
);
  // ----------------------------------------
  // power-on: pin held low while power comes up
  // ----------------------------------------
  initial begin
    power_down_n = 1'b0;
    repeat (POWERON_CYC) @(negedge clk_sys);
    power_down_n = 1'b1;
  end

  task automatic sleep_begin;
    @(negedge clk_sys);
    power_down_n = 1'b0;
  endtask : sleep_begin

  // pulse width counted locally, no device feedback
  task automatic wake;
    repeat (PULSE_CYC) @(negedge clk_sys);
    power_down_n = 1'b1;
  endtask : wake
endmodule : rsws_host_model

// ### test/tb_top.sv
// testbench: sleep/wake latencies against a counting model
`timescale 1ns/100ps
module tb_top;
  import rsws_pkg::*;
  localparam int CNT   = 20;
  localparam int STB   = 25;
  localparam int RST_CYC = 32500;
  logic         clk_sys = 1'b0;
  logic         reset = 1'b1;
  logic         ce = 1'b1;
  logic         pd_n;
  logic [1:0]   irq_config = 2'h0;
  logic         wake_enable = 1'b0;
  logic         irq_clear = 1'b0;
  rsws_status_t status;
  rsws_pin_t    irq_pin;
  logic         osc_en;
  logic         irq_line;
  int           err_count = 0;
  int           checks = 0;
  int           seed = 32'h37248fb3;

  always #20 clk_sys = ~clk_sys;

  // pull-up on the interrupt line
  assign irq_line = irq_pin.oe ? irq_pin.o : 1'b1;

  rsws_host_model host (.clk_sys(clk_sys), .power_down_n(pd_n));

  rsws_top #(.OSC_OUT_CNT(CNT), .CLOCKS_CNT(CNT), .IRQ_CNT(CNT), .STABLE_CNT(STB),
             .IRQ_STABLE_CNT(STB)) DUT (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .power_down_n(pd_n),
    .irq_config(irq_config), .wake_enable(wake_enable), .irq_clear(irq_clear),
    .status(status), .irq_pin(irq_pin), .buffered_osc_output_en(osc_en));

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // wake: first cycle each output reaches its active level, from release
  // ----------------------------------------
  task automatic measure(input logic wen);
    int   t[4];
    logic lvl;
    logic oe_exp;
    for (int k = 0; k < 4; k++) t[k] = -1;
    for (int n = 1; n <= 60; n++) begin
      @(negedge clk_sys);
      if (t[0] < 0 && osc_en === 1'b1) t[0] = n;
      if (t[1] < 0 && status.clocks_running === 1'b1) t[1] = n;
      if (t[2] < 0 && status.clock_stable === 1'b1) t[2] = n;
      if (t[3] < 0 && irq_line === irq_config[0]) t[3] = n;
    end
    check(4'(t[0] >= CNT && t[0] <= CNT + 6), 4'h1);
    check(4'(t[1] >= CNT && t[1] <= CNT + 6), 4'h1);
    check(4'(t[2] >= STB && t[2] <= STB + 6), 4'h1);
    check(4'(wen ? (t[3] >= CNT && t[3] <= CNT + 7) : t[3] < 0), 4'h1);
    check(4'(!wen || t[2] >= t[3]), 4'h1);
    lvl    = wen ? irq_config[0] : ~irq_config[0];
    oe_exp = ~irq_config[1] | ~lvl;
    check({3'h0, irq_line}, {3'h0, lvl});
    check({3'h0, irq_pin.oe}, {3'h0, oe_exp});
    irq_clear <= 1'b1;
    repeat (3) @(negedge clk_sys);
    irq_clear <= 1'b0;
    check({3'h0, irq_line}, {3'h0, ~irq_config[0]});
  endtask : measure

  task automatic sleep_check;
    int t;
    t = -1;
    host.sleep_begin();
    for (int n = 1; n <= 8; n++) begin
      @(negedge clk_sys);
      if (t < 0 && status.low_power === 1'b1) t = n;
    end
    check(4'(t >= 1 && t <= 4), 4'h1);
    check(status, 4'h1);
    check({3'h0, osc_en}, 4'h0);
  endtask : sleep_check

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(status, 4'h1);
    irq_config = 2'($random(seed));
    wake_enable = 1'b1;
    wait (pd_n === 1'b1);
    measure(1'b1);
    for (int i = 0; i < 4; i++) begin
      sleep_check();
      irq_config = 2'($random(seed));
      wake_enable = 1'($random(seed));
      host.wake();
      measure(wake_enable);
    end
    // second power-up: reset and power-down held together
    sleep_check();
    reset = 1'b1;
    repeat (RST_CYC) @(negedge clk_sys);
    reset = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(status, 4'h1);
    check({3'h0, irq_line}, {3'h0, ~irq_config[0]});
    host.wake();
    measure(wake_enable);
    print_verdict();
  end

  initial begin
    #3200000;
    err_count++;
    print_verdict();
  end
endmodule : tb_top
